// *** src/logic_equation_bank.sv ***
// bank of cascaded logic equations evaluated one per clock in index order
// assumes an apb master on clk_sys; ext_in are asynchronous pins
`timescale 1ns/1ps
module logic_equation_bank #(
    parameter int NUM_EQ  = logic_equation_pkg::NUM_EQ,
    parameter int NUM_EXT = logic_equation_pkg::NUM_EXT
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic [NUM_EXT-1:0]  ext_in,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic      [NUM_EQ-1:0]   eq_direct,
    output logic      [NUM_EQ-1:0]   eq_latched,
    output logic      [NUM_EQ-1:0]   eq_latched_n
);
    localparam int SW  = logic_equation_pkg::SEL_W;
    localparam int DW  = logic_equation_pkg::DLY_W;
    localparam int NSIG = 1 + NUM_EXT + 3 * NUM_EQ;
    localparam int IW  = $clog2(NUM_EQ);
    localparam int CC  = logic_equation_pkg::CYCLE_CLKS;

    initial begin
        if (NSIG > (1 << SW) || NUM_EQ < 2 || NUM_EQ > 128)
            $error("logic_equation_bank: unsupported size");
    end

    // configuration and state storage
    logic [NUM_EQ-1:0][31:0]   cfg_word;
    logic [NUM_EQ-1:0][31:0]   dly_word;
    logic [NUM_EQ-1:0]         gate_q;
    logic [NUM_EQ-1:0][DW-1:0] tmr;
    logic [NUM_EQ-1:0]         dir_q;
    logic [NUM_EQ-1:0]         lat_q;
    logic [NUM_EXT-1:0]        ext_s1;
    logic [NUM_EXT-1:0]        ext_s2;
    logic [NUM_EXT-1:0]        ext_snap;
    logic [IW-1:0]             idx;
    logic [15:0]               pace;

    typedef enum logic [0:0] {ST_WAIT, ST_SWEEP} sweep_e;
    sweep_e state;

    // signal vector: index 0 unassigned, then ext, then dir/lat/lat_n
    logic [(1 << SW)-1:0] sig_vec;
    always_comb begin
        sig_vec = '0;
        sig_vec[NUM_EXT:1] = ext_snap;
        for (int e = 0; e < NUM_EQ; e++) begin
            sig_vec[1 + NUM_EXT + 3*e]     = dir_q[e];
            sig_vec[1 + NUM_EXT + 3*e + 1] = lat_q[e];
            sig_vec[1 + NUM_EXT + 3*e + 2] = ~lat_q[e];
        end
    end

    // pick one signal by select code
    function automatic logic pick(input logic [(1 << SW)-1:0] v,
                                  input logic [SW-1:0] s);
        pick = v[s];
    endfunction

    // evaluation of the current equation
    logic_equation_pkg::eq_cfg_s cur;
    assign cur = logic_equation_pkg::eq_cfg_s'(cfg_word[idx]);

    logic [3:0] term;
    logic [3:0] assigned;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_in
            // unassigned inputs become neutral for the gate
            assign assigned[gi] = cur.input_sel[gi] != logic_equation_pkg::SEL_NONE;
            assign term[gi] = assigned[gi]
                ? pick(sig_vec, cur.input_sel[gi]) ^ cur.input_inv[gi]
                : (cur.gate == logic_equation_pkg::GATE_AND ||
                   cur.gate == logic_equation_pkg::GATE_NAND);
        end
    endgenerate

    // gate function; no input assigned gives false for and, true for nand
    logic gate_raw;
    logic gate_val;
    assign gate_raw = (cur.gate == logic_equation_pkg::GATE_AND ||
                       cur.gate == logic_equation_pkg::GATE_NAND)
                      ? (&term && |assigned) : |term;
    assign gate_val = (cur.gate == logic_equation_pkg::GATE_NAND ||
                       cur.gate == logic_equation_pkg::GATE_NOR)
                      ? ~gate_raw : gate_raw;

    // timer stage: counts process cycles while gate differs from output
    logic [DW-1:0] rise_d;
    logic [DW-1:0] fall_d;
    logic [DW-1:0] need;
    logic [DW-1:0] next_tmr;
    logic          next_dir;
    logic          differs;
    assign rise_d  = dly_word[idx][logic_equation_pkg::DLY_RISE +: DW];
    assign fall_d  = dly_word[idx][logic_equation_pkg::DLY_FALL +: DW];
    assign need    = gate_val ? rise_d : fall_d;
    assign differs = gate_val != dir_q[idx];
    // a shorter transition resets the count and is lost
    assign next_tmr = !differs ? '0
                    : (tmr[idx] >= need ? '0 : tmr[idx] + 1'b1);
    assign next_dir = differs && (tmr[idx] >= need) ? gate_val
                    : dir_q[idx];

    // latch with dominant reset
    logic rst_lat;
    logic next_lat;
    assign rst_lat = (cur.reset_sel != logic_equation_pkg::SEL_NONE) &&
                     (pick(sig_vec, cur.reset_sel) ^ cur.reset_inv);
    assign next_lat = rst_lat ? 1'b0 : (lat_q[idx] | next_dir);

    // input synchroniser
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_s1 <= '0;
            ext_s2 <= '0;
        end else begin
            ext_s1 <= ext_in;
            ext_s2 <= ext_s1;
        end
    end

    // process cycle pacing and ascending sweep
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state    <= ST_WAIT;
            idx      <= '0;
            pace     <= '0;
            ext_snap <= '0;
        end else begin
            pace <= (pace == 16'(CC - 1)) ? '0 : pace + 16'h0001;
            case (state)
                ST_WAIT: begin
                    if (pace == 16'h0000) begin
                        ext_snap <= ext_s2; // inputs frozen for a sweep
                        idx      <= '0;
                        state    <= ST_SWEEP;
                    end
                end
                ST_SWEEP: begin
                    if (idx == IW'(NUM_EQ - 1)) begin
                        state <= ST_WAIT;
                    end else begin
                        idx <= idx + 1'b1;
                    end
                end
                default: state <= ST_WAIT;
            endcase
        end
    end

    // equation state: updated in place, so later equations see it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tmr    <= '0;
            dir_q  <= '0;
            lat_q  <= '0;
            gate_q <= '0;
        end else if (state == ST_SWEEP) begin
            tmr[idx]    <= next_tmr;
            dir_q[idx]  <= next_dir;
            lat_q[idx]  <= next_lat;
            gate_q[idx] <= gate_val;
        end
    end

    // outputs updated at the end of every sweep
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            eq_direct    <= '0;
            eq_latched   <= '0;
            eq_latched_n <= '1;
        end else if (state == ST_WAIT) begin
            eq_direct    <= dir_q;
            eq_latched   <= lat_q;
            eq_latched_n <= ~lat_q;
        end
    end

    // apb decode
    logic [IW-1:0] a_eq;
    logic [11:0]   a_ofs;
    logic          a_eqspace;
    logic          a_hit;
    logic          acc;
    logic [31:0]   rd_val;
    assign a_eq      = paddr[4 +: IW];
    assign a_ofs     = paddr & 12'h00F;
    assign a_eqspace = paddr < 12'(NUM_EQ * 16) && paddr[1:0] == 2'b00;
    assign acc       = psel && penable && !pready;
    assign a_hit = (a_eqspace && a_ofs != 12'h00C) ||
                   paddr == logic_equation_pkg::OFS_EXT ||
                   paddr == logic_equation_pkg::OFS_OUTS;
    assign rd_val =
        !a_eqspace ? (paddr == logic_equation_pkg::OFS_EXT
                        ? 32'(ext_s2)
                        : 32'({eq_latched, eq_direct}))
        : a_ofs == logic_equation_pkg::OFS_CFG ? cfg_word[a_eq]
        : a_ofs == logic_equation_pkg::OFS_DLY ? dly_word[a_eq]
        : {28'h0000000, 1'b0, lat_q[a_eq], dir_q[a_eq], gate_q[a_eq]};

    // apb slave: one wait cycle, writes land at the pready edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0000_0000;
            cfg_word <= {NUM_EQ{logic_equation_pkg::CFG_RESET}};
            dly_word <= {NUM_EQ{logic_equation_pkg::DLY_RESET}};
        end else begin
            pready  <= acc;
            pslverr <= acc && !a_hit;
            prdata  <= (acc && a_hit && !pwrite) ? rd_val : 32'h0000_0000;
            if (acc && pwrite && a_eqspace) begin
                if (a_ofs == logic_equation_pkg::OFS_CFG)
                    cfg_word[a_eq] <= pwdata;
                if (a_ofs == logic_equation_pkg::OFS_DLY)
                    dly_word[a_eq] <= pwdata;
            end
        end
    end
endmodule

// *** src/logic_equation_pkg.sv ***
// package for the cascaded logic equation bank
// assumes apb master on clk_sys and one register word per aligned address
package logic_equation_pkg;
    // gate functions
    typedef enum logic [1:0] {
        GATE_AND,
        GATE_OR,
        GATE_NAND,
        GATE_NOR
    } gate_e;

    localparam int NUM_EQ       = 8;
    localparam int NUM_EXT      = 16;
    localparam int SEL_W        = 5;
    localparam int DLY_W        = 16;
    // timing: one process cycle every CYCLE_TIME_US microseconds
    localparam int CYCLE_TIME_US = 1;
    localparam int CLK_MHZ       = 200;
    localparam int CYCLE_CLKS    = CYCLE_TIME_US * CLK_MHZ;

    // signal select: 0 unassigned, 1..NUM_EXT external, then eq outputs
    localparam logic [SEL_W-1:0] SEL_NONE = 5'h00;

    // per equation register block: base + 16*eq
    localparam logic [11:0] EQ_STRIDE   = 12'h010;
    localparam logic [11:0] OFS_CFG     = 12'h000;
    localparam logic [11:0] OFS_DLY     = 12'h004;
    localparam logic [11:0] OFS_STAT    = 12'h008;
    localparam logic [11:0] OFS_EXT     = 12'h800;
    localparam logic [11:0] OFS_OUTS    = 12'h804;

    // configuration and delay word field positions, reset values
    localparam int CFG_SEL0   = 0;
    localparam int CFG_INV    = 20;
    localparam int CFG_GATE   = 24;
    localparam int CFG_RSEL   = 26;
    localparam int CFG_RINV   = 31;
    localparam int DLY_RISE   = 0;
    localparam int DLY_FALL   = 16;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] DLY_RESET = 32'h0000_0000;

    // one equation's configuration
    typedef struct packed {
        logic             reset_inv;
        logic [SEL_W-1:0] reset_sel;
        gate_e            gate;
        logic [3:0]       input_inv;
        logic [3:0][SEL_W-1:0] input_sel;
    } eq_cfg_s;

    // one equation's results
    typedef struct packed {
        logic latched_n;
        logic latched;
        logic direct;
    } eq_out_s;
endpackage

// *** verif/ext_source.sv ***
// model of the pickups and module inputs feeding the bank
// assumes the bench requests levels on clk_sys
`timescale 1ns/1ps
module ext_source (
    input  wire logic        clk_sys,
    input  wire logic [15:0] req,
    output logic      [15:0] ext_in
);
    // signals change once per clock like a scanned input card
    always_ff @(posedge clk_sys) ext_in <= req;
endmodule

// *** verif/logic_equation_bank_tb.sv ***
// self-checking bench for the logic equation bank
// assumes NUM_EQ 5 so all select codes fit in five bits
`timescale 1ns/1ps
module logic_equation_bank_tb;
    localparam int NEQ = 5;
    localparam int PC  = logic_equation_pkg::CYCLE_CLKS;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, rd;
    logic [15:0] req = '0;
    wire [15:0] ext_in;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [NEQ-1:0] eq_direct, eq_latched, eq_latched_n;
    int err_total = 0, comparisons = 0;
    logic [3:0] lt [5] = '{4'h5, 4'h4, 4'h3, 4'hF, 4'h8};
    logic_equation_pkg::eq_cfg_s c, cf [NEQ];
    logic_equation_bank #(.NUM_EQ(NEQ)) i_logic_equation_bank (.clk_sys,
        .rst, .ext_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .eq_direct, .eq_latched, .eq_latched_n);
    ext_source i_ext_source (.clk_sys, .req, .ext_in);
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask
    task automatic setcfg(input int q, input logic [31:0] d, dl);
        apb(1, 12'(q * 16), d);
        apb(1, 12'(q * 16 + 4), dl);
    endtask
    task automatic wait_pc(input int n);
        repeat (n * PC) @(posedge clk_sys);
    endtask
    // or gate on one selected signal
    function automatic logic_equation_pkg::eq_cfg_s mk(logic [4:0] s);
        mk = '0;
        mk.input_sel[0] = s;
        mk.gate = logic_equation_pkg::GATE_OR;
    endfunction
    // expected gate result; gate bit0 picks or, bit1 inverts
    function automatic logic f_eval(logic_equation_pkg::eq_cfg_s q,
                                    logic [15:0] x);
        logic a, o, v;
        a = 1;
        o = 0;
        for (int i = 0; i < 4; i++) if (q.input_sel[i] != 0) begin
            v = x[q.input_sel[i] - 1] ^ q.input_inv[i];
            a &= v;
            o |= v;
        end
        return (q.gate[0] ? o : a) ^ q.gate[1];
    endfunction
    task automatic wrap_up;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hEB809807));
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        // reset values, refused offset, read back
        apb(0, 12'h000, 0);
        chk(rd, logic_equation_pkg::CFG_RESET);
        apb(0, 12'h014, 0);
        chk(rd, logic_equation_pkg::DLY_RESET);
        apb(0, 12'h00C, 0);
        chk(32'(e), 32'h00000001);
        chk(rd, 32'h00000000);
        apb(1, 12'h020, 32'hA5A5A5A5);
        apb(0, 12'h020, 0);
        chk(rd, 32'hA5A5A5A5);
        // random selects, inversions and gates from external signals
        for (int k = 0; k < 12; k++) begin
            for (int q = 0; q < NEQ; q++) begin
                c = $urandom;
                for (int i = 1; i < 4; i++) c.input_sel[i] = $urandom % 17;
                c.input_sel[0] = 1 + $urandom % 16;
                c.reset_sel = '0;
                cf[q] = c;
                setcfg(q, c, 0);
            end
            req <= $urandom;
            wait_pc(3);
            for (int q = 0; q < NEQ; q++) chk(eq_direct[q], f_eval(cf[q], req));
            apb(0, 12'h804, 0);
            chk(rd[NEQ-1:0], eq_direct);
            chk(rd[2*NEQ-1:NEQ], eq_latched);
        end
        // chain 0->1->2 forward, 4->3 backward
        setcfg(0, mk(5'h01), 0);
        setcfg(1, mk(5'h11), 0);
        setcfg(2, mk(5'h14), 0);
        setcfg(3, mk(5'h1D), 0);
        setcfg(4, mk(5'h01), 0);
        req <= '0;
        wait_pc(3);
        req <= 16'h0001;
        for (int n = 0; n < 3 * PC && eq_direct[4] !== 1'b1; n++) @(posedge clk_sys);
        chk(eq_direct, 5'h17);
        repeat (PC + 2) @(posedge clk_sys);
        chk(eq_direct, 5'h1F);
        // latch with reset on ext1: {rinv, expected, ext1, ext0}
        c = mk(5'h01);
        c.reset_sel = 5'h02;
        for (int s = 0; s < 5; s++) begin
            c.reset_inv = lt[s][3];
            setcfg(0, c, 0);
            req <= {14'h0, lt[s][1:0]};
            wait_pc(3);
            chk(eq_latched[0], lt[s][2]);
        end
        // rise delay 3, fall delay 2; one-cycle pulse is swallowed
        setcfg(0, mk(5'h01), 32'h00020003);
        req <= '0;
        wait_pc(3);
        req <= 16'h0001;
        wait_pc(1);
        req <= '0;
        wait_pc(6);
        chk(eq_direct[0], 1'b0);
        req <= 16'h0001;
        wait_pc(2);
        chk(eq_direct[0], 1'b0);
        wait_pc(5);
        chk(eq_direct[0], 1'b1);
        req <= '0;
        wait_pc(1);
        chk(eq_direct[0], 1'b1);
        wait_pc(6);
        chk(eq_direct[0], 1'b0);
        wrap_up();
    end
endmodule

// *** verif/logic_equation_checker.sv ***
// port checker for the logic equation bank
// assumes one apb wait state and outputs refreshed once per process cycle
`timescale 1ns/1ps
module logic_equation_checker #(
    parameter int NUM_EQ  = 5,
    parameter int NUM_EXT = 16
) (
    input wire logic               clk_sys,
    input wire logic               rst,
    input wire logic [NUM_EXT-1:0] ext_in,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [NUM_EQ-1:0]  eq_direct,
    input wire logic [NUM_EQ-1:0]  eq_latched,
    input wire logic [NUM_EQ-1:0]  eq_latched_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // apb answer timing
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_idle_ready: assert property (!psel |=> !pready)
        else $error("pready without access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // equation outputs
    a_latch_compl: assert property (eq_latched_n == ~eq_latched)
        else $error("latched complement wrong");
    a_latch_set: assert property ((eq_latched & ~$past(eq_latched) & ~eq_direct) == '0)
        else $error("latch set without direct");
    a_direct_hold: assert property ($changed(eq_direct) |=> $stable(eq_direct)[*8])
        else $error("direct changed twice");
    a_latch_hold: assert property ($changed(eq_latched) |=> $stable(eq_latched)[*8])
        else $error("latched changed twice");
    a_reset_vals: assert property ($fell(rst) |-> eq_direct == '0 && eq_latched_n == '1)
        else $error("outputs not at reset value");
endmodule
bind logic_equation_bank logic_equation_checker #(
    .NUM_EQ(NUM_EQ), .NUM_EXT(NUM_EXT)) i_logic_equation_checker (
    .clk_sys, .rst, .ext_in, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .eq_direct, .eq_latched, .eq_latched_n);
